// ===== rtl/psuh_pkg.sv
// Types shared by the state-update handler and its surroundings.
// Assumes the constants header is on the include path.
`default_nettype none
`include "psuh_regs.svh"
package psuh_pkg;
	typedef struct packed {
		logic [15:0] rid;
		logic [19:0] pasid;
		logic typ;
	} psuh_req_s;
	typedef struct packed {
		logic [15:0] rid;
		logic [19:0] pasid;
		logic typ;
		logic resync;
		logic code;
	} psuh_rsp_s;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CHECK = 3'b001,
		S_RD = 3'b010,
		S_WR = 3'b011,
		S_INV = 3'b100,
		S_RSP = 3'b101
	} psuh_state_e;
endpackage : psuh_pkg
`default_nettype wire

// ===== rtl/psuh_regs.svh
// Register offsets, field positions, reset values and codes of the
// address-space state-update handler. Included by the handler package.
`ifndef PSUH_REGS_SVH
`define PSUH_REGS_SVH
`define PSUH_CAP_OFF 12'h000
`define PSUH_CTRL_OFF 12'h004
`define PSUH_STAT_OFF 12'h008
`define PSUH_CTX_BASE 4'h1
`define PSUH_CTRL_RST 32'h0000_0001
`define PSUH_CAP_DIS_BIT 0
`define PSUH_CTRL_EN_BIT 0
`define PSUH_STAT_BUSY_BIT 0
`define PSUH_STAT_CODE_BIT 1
`define PSUH_CTX_PRES_BIT 0
`define PSUH_CTX_ASID_BIT 1
`define PSUH_CTX_DEFERRED_INVAL_ENABLE_BIT 2
`define PSUH_CTX_TSF_LSB 4
`define PSUH_CTX_PTR_LSB 12
`define PSUH_TBL_MIN_LOG 5'd5
`define PSUH_ENT_PEND_BIT 0
`define PSUH_ENT_CNT_LSB 1
`define PSUH_GRAN_PASID 3'b011
`define PSUH_RC_OK 1'b0
`define PSUH_RC_INVALID 1'b1
`endif

// ===== rtl/psuh_top.sv
// Address-space state-update handler: takes requests from the accelerator,
// updates the per-PASID state entry in memory and answers each request.
// Assumes an AHB-Lite master, a memory port that honours the lock signal,
// and an IOTLB that acknowledges each invalidation with inv_done.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`default_nettype none
`include "psuh_regs.svh"
// Operation
// - Response copies identity, PASID and type from its request.
// - Response code 0 means success, 1 means invalid request.
// - Requester identity selects the governing context entry.
// - Bad entry, mechanism off, PASID too big: invalid, table untouched.
// - Without error the PASID indexes the state table.
// - State entry is read locked, updated, then unlocked atomically.
// - Active request increments count and clears pending flag.
// - Inactive request decrements count, keeps pending flag.
// - Active with pending flag set: invalidate IOTLB, resync set.
// - That invalidation uses code 011b and ends before the response.
// - Otherwise resync is cleared in the response.
// - Error-free processing answers success with the computed resync.
// - Capability bit reports support; context entry enables per device.
// - Enabled context entry supplies table pointer and table size.
// - Software sets pending flag; hardware clears it on active requests and derives resync and the invalidation from it.
module psuh_top #(
	parameter int CTX_AW = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic req_valid,
	input wire psuh_pkg::psuh_req_s req,
	output logic req_ready,
	output logic rsp_valid,
	output psuh_pkg::psuh_rsp_s rsp,
	input wire logic rsp_ready,
	output logic mem_req,
	output logic mem_wr,
	output logic mem_lock,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic mem_err,
	input wire logic [31:0] mem_rdata,
	output logic inv_req,
	output logic [2:0] inv_gran,
	output logic [19:0] inv_pasid,
	input wire logic inv_done
);
	import psuh_pkg::*;

	localparam int NCTX = 2 ** CTX_AW;

	logic [31:0] ctx_q [NCTX];
	logic [31:0] ctrl_q;
	logic [15:0] rsp_cnt_q;
	logic last_code_q;
	logic ap_wr_q, ap_rd_q;
	logic [11:0] ap_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	psuh_state_e state_q;
	psuh_req_s cur_q;
	psuh_rsp_s rsp_q;
	logic rsp_valid_q, req_ready_q;
	logic mem_req_q, mem_wr_q, mem_lock_q;
	logic [31:0] mem_addr_q, mem_wdata_q, ent_q;
	logic inv_req_q;
	logic [31:0] ctx_sel_q;

	// Bus decode.
	wire ap_take = hsel & htrans[1] & hready;
	wire [11:0] ap_a = haddr[11:0];
	wire ctx_hit = ap_addr_q[11:8] == `PSUH_CTX_BASE &&
		ap_addr_q[7:2] < 6'(NCTX);
	wire [CTX_AW-1:0] ctx_widx = ap_addr_q[CTX_AW+1:2];
	wire [31:0] cap_val = 32'h1 << `PSUH_CAP_DIS_BIT;
	wire busy = state_q != S_IDLE;
	wire [31:0] stat_val = {rsp_cnt_q, 14'h0, last_code_q, busy};
	wire [31:0] rd_val =
		(ap_addr_q == `PSUH_CAP_OFF) ? cap_val :
		(ap_addr_q == `PSUH_CTRL_OFF) ? ctrl_q :
		(ap_addr_q == `PSUH_STAT_OFF) ? stat_val :
		ctx_hit ? ctx_q[ctx_widx] : 32'h0;
	wire en = ctrl_q[`PSUH_CTRL_EN_BIT];

	// Context entry fields of the latched entry.
	wire c_pres = ctx_sel_q[`PSUH_CTX_PRES_BIT];
	wire c_asid = ctx_sel_q[`PSUH_CTX_ASID_BIT];
	wire c_deferred_inval_enable = ctx_sel_q[`PSUH_CTX_DEFERRED_INVAL_ENABLE_BIT];
	wire [3:0] c_tsf = ctx_sel_q[`PSUH_CTX_TSF_LSB+:4];
	wire [19:0] c_ptr = ctx_sel_q[`PSUH_CTX_PTR_LSB+:20];
	// Table holds 2^(size field + 5) entries.
	wire [4:0] tbl_log = {1'b0, c_tsf} + `PSUH_TBL_MIN_LOG;
	wire pasid_oob = (cur_q.pasid >> tbl_log) != 20'h0;
	wire ctx_bad = !c_pres | !c_asid | !c_deferred_inval_enable | pasid_oob;
	wire [31:0] ent_addr = {c_ptr, 12'h000} +
		{10'h0, cur_q.pasid, 2'b00};

	// Read-modify-write of the state entry.
	wire rd_pend = mem_rdata[`PSUH_ENT_PEND_BIT];
	wire [30:0] rd_cnt = mem_rdata[31:`PSUH_ENT_CNT_LSB];
	// A decrement at zero saturates so a stray preemption cannot wrap.
	wire [30:0] dec_cnt = (rd_cnt == 31'h0) ? 31'h0 : rd_cnt - 31'h1;
	wire [30:0] new_cnt = cur_q.typ ? rd_cnt + 31'h1 : dec_cnt;
	wire new_pend = cur_q.typ ? 1'b0 : rd_pend;
	wire [31:0] new_ent = {new_cnt, new_pend};
	// Pending flag feeds the resync bit and the IOTLB invalidation.
	wire need_inv = cur_q.typ & ent_q[`PSUH_ENT_PEND_BIT];

	wire req_fire = req_valid & req_ready_q;
	wire rsp_fire = rsp_valid_q & rsp_ready;
	wire mem_fire = mem_req_q & mem_ack;

	always_ff @(posedge clk) begin
		if (rst) begin
			ap_wr_q <= 1'b0;
			ap_rd_q <= 1'b0;
			ap_addr_q <= 12'h0;
			hrdata_q <= 32'h0;
			hreadyout_q <= 1'b1;
		end else begin
			ap_wr_q <= ap_take & hwrite;
			ap_rd_q <= ap_take & !hwrite;
			if (ap_take) begin
				ap_addr_q <= ap_a;
			end
			// Reads take one wait state so that hrdata comes from a flop.
			hreadyout_q <= !(ap_take & !hwrite);
			if (ap_rd_q) begin
				hrdata_q <= rd_val;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `PSUH_CTRL_RST;
		end else if (ap_wr_q && ap_addr_q == `PSUH_CTRL_OFF) begin
			ctrl_q <= {31'h0, hwdata[`PSUH_CTRL_EN_BIT]};
		end
	end

	// Context entries come up not present, so any request is refused.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NCTX; i++) begin
				ctx_q[i] <= 32'h0;
			end
		end else if (ap_wr_q && ctx_hit) begin
			ctx_q[ctx_widx] <= hwdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			cur_q <= '0;
			ctx_sel_q <= 32'h0;
			req_ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
			mem_req_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_lock_q <= 1'b0;
			mem_addr_q <= 32'h0;
			mem_wdata_q <= 32'h0;
			ent_q <= 32'h0;
			inv_req_q <= 1'b0;
			rsp_cnt_q <= 16'h0;
			last_code_q <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					req_ready_q <= en & !req_fire;
					if (req_fire) begin
						cur_q <= req;
						ctx_sel_q <= ctx_q[req.rid[CTX_AW-1:0]];
						state_q <= S_CHECK;
					end
				end
				S_CHECK: begin
					rsp_q.rid <= cur_q.rid;
					rsp_q.pasid <= cur_q.pasid;
					rsp_q.typ <= cur_q.typ;
					if (ctx_bad) begin
						rsp_q.code <= `PSUH_RC_INVALID;
						rsp_q.resync <= 1'b0;
						rsp_valid_q <= 1'b1;
						state_q <= S_RSP;
					end else begin
						mem_req_q <= 1'b1;
						mem_wr_q <= 1'b0;
						mem_lock_q <= 1'b1;
						mem_addr_q <= ent_addr;
						state_q <= S_RD;
					end
				end
				S_RD: begin
					if (mem_fire) begin
						if (mem_err) begin
							mem_req_q <= 1'b0;
							mem_lock_q <= 1'b0;
							rsp_q.code <= `PSUH_RC_INVALID;
							rsp_q.resync <= 1'b0;
							rsp_valid_q <= 1'b1;
							state_q <= S_RSP;
						end else begin
							ent_q <= mem_rdata;
							mem_wr_q <= 1'b1;
							mem_wdata_q <= new_ent;
							state_q <= S_WR;
						end
					end
				end
				S_WR: begin
					if (mem_fire) begin
						mem_req_q <= 1'b0;
						mem_wr_q <= 1'b0;
						mem_lock_q <= 1'b0;
						// A failed write is an invalid request, never a resync.
						rsp_q.resync <= need_inv & !mem_err;
						rsp_q.code <= mem_err ? `PSUH_RC_INVALID :
							`PSUH_RC_OK;
						if (need_inv && !mem_err) begin
							inv_req_q <= 1'b1;
							state_q <= S_INV;
						end else begin
							rsp_valid_q <= 1'b1;
							state_q <= S_RSP;
						end
					end
				end
				S_INV: begin
					if (inv_done) begin
						inv_req_q <= 1'b0;
						rsp_valid_q <= 1'b1;
						state_q <= S_RSP;
					end
				end
				S_RSP: begin
					if (rsp_fire) begin
						rsp_valid_q <= 1'b0;
						rsp_cnt_q <= rsp_cnt_q + 16'h1;
						last_code_q <= rsp_q.code;
						req_ready_q <= en;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign req_ready = req_ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp = rsp_q;
	assign mem_req = mem_req_q;
	assign mem_wr = mem_wr_q;
	assign mem_lock = mem_lock_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign inv_req = inv_req_q;
	assign inv_gran = `PSUH_GRAN_PASID;
	assign inv_pasid = cur_q.pasid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	rsp_copy_a: assert property ($rose(rsp_valid_q) |->
		rsp_q.rid == cur_q.rid && rsp_q.pasid == cur_q.pasid &&
		rsp_q.typ == cur_q.typ)
		else $error("response fields differ from request");
	bad_ctx_a: assert property (state_q == S_CHECK && ctx_bad |=>
		state_q == S_RSP && rsp_q.code && !mem_req_q)
		else $error("bad context entry not refused");
	mem_err_a: assert property (state_q == S_RD && mem_fire &&
		mem_err |=> rsp_valid_q && rsp_q.code && !mem_lock_q)
		else $error("entry access error not reported");
	ent_idx_a: assert property (state_q == S_RD |->
		mem_addr_q == ent_addr && mem_lock_q && !mem_wr_q)
		else $error("state entry address wrong");
	lock_hold_a: assert property (state_q == S_RD && mem_fire &&
		!mem_err |=> mem_lock_q && mem_wr_q && mem_req_q)
		else $error("lock dropped between read and write");
	act_upd_a: assert property (state_q == S_WR && cur_q.typ |->
		mem_wdata_q[31:1] == ent_q[31:1] + 31'h1 && !mem_wdata_q[0])
		else $error("active update wrong");
	inact_upd_a: assert property (state_q == S_WR && !cur_q.typ |->
		mem_wdata_q[0] == ent_q[0] &&
		mem_wdata_q[31:1] == (ent_q[31:1] == 31'h0 ? 31'h0 :
		ent_q[31:1] - 31'h1))
		else $error("inactive update wrong");
	inv_start_a: assert property (state_q == S_WR && mem_fire &&
		!mem_err && need_inv |=> inv_req_q && inv_gran == 3'b011)
		else $error("pending invalidation not issued");
	inv_first_a: assert property (inv_req_q |-> !rsp_valid_q)
		else $error("response sent before invalidation done");
	sync_clr_a: assert property (rsp_valid_q && (!rsp_q.typ ||
		!ent_q[0]) && !rsp_q.code |-> !rsp_q.resync)
		else $error("resync set without pending flag");
	err_sync_a: assert property (rsp_valid_q && rsp_q.code |->
		!rsp_q.resync)
		else $error("resync set on failed response");
	one_at_a: assert property (state_q != S_IDLE |-> !req_ready_q)
		else $error("new request taken while busy");
	rsp_hold_a: assert property (rsp_valid_q && !rsp_ready |=>
		rsp_valid_q && $stable(rsp_q))
		else $error("response changed before accepted");
endmodule // psuh_top
`default_nettype wire

// ===== verif/pasid_state_update_handler_tb_top.sv
// Bench for the state-update handler: AHB-Lite master and accelerator.
// Assumes the handler package and the memory model are compiled first.
`default_nettype none
module pasid_state_update_handler_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import psuh_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] stall = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic req_valid = 1'b0;
	logic rsp_ready = 1'b0;
	logic [1:0] fail = 2'h0;
	psuh_req_s req = '0;
	psuh_rsp_s rsp;
	logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata, rd;
	logic hreadyout, hresp, req_ready, rsp_valid, mem_req, mem_wr, mem_lock;
	logic mem_ack, mem_err, inv_req, inv_done;
	logic [2:0] inv_gran, gran_seen;
	logic [19:0] inv_pasid, pasid_seen;
	int miscompares = 0;
	int compares = 0;
	int invs = 0;
	int mems = 0;
	int lock_bad = 0;
	int flushes = 0;
	int kills = 0;
	int n;
	always #12.5 clk = ~clk;
	psuh_top u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
		.rsp_ready(rsp_ready), .mem_req(mem_req), .mem_wr(mem_wr),
		.mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
		.inv_req(inv_req), .inv_gran(inv_gran), .inv_pasid(inv_pasid),
		.inv_done(inv_done));
	psuh_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .inv_req(inv_req),
		.stall(stall), .fail(fail), .mem_ack(mem_ack), .mem_err(mem_err),
		.mem_rdata(mem_rdata), .inv_done(inv_done));
	always @(posedge clk) begin
		if (mem_req && mem_ack) begin
			mems <= mems + 1;
			lock_bad <= lock_bad + int'(!mem_lock);
		end
		if (inv_req && inv_done) begin
			invs <= invs + 1;
			gran_seen <= inv_gran;
			pasid_seen <= inv_pasid;
		end
	end
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Waits for hready, req_ready or rsp_valid, chosen by sel.
	task automatic wait_hi(input int sel);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((sel == 0 ? hreadyout : sel == 1 ? req_ready : rsp_valid)
			!== 1'b1 && n < 200);
		if (n >= 200) begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		wait_hi(0);
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(0);
		rd = hrdata;
	endtask
	task automatic upd(input logic [15:0] rid, input logic [19:0] pa,
		input logic ty, input logic rs, input logic cd);
		req_valid <= 1'b1;
		req <= {rid, pa, ty};
		wait_hi(1);
		req_valid <= 1'b0;
		@(posedge clk);
		chk("req_ready busy", 64'h0, req_ready);
		wait_hi(2);
		chk("rsp", {rid, pa, ty, rs, cd}, rsp);
		// The accelerator flushes its own TLB or kills the PASID's tasks.
		if (!rsp.code && rsp.resync && rsp.typ) begin
			flushes++;
		end
		if (rsp.code) begin
			kills++;
		end
		rsp_ready <= 1'b1;
		@(posedge clk);
		rsp_ready <= 1'b0;
	endtask
	initial begin
		u_mem.mem[5] = 32'h7;
		u_mem.mem[9'h128] = 32'h1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, 32'h0, 32'h0);
		chk("cap", 64'h1, rd);
		ahb(1'b0, 32'h4, 32'h0);
		chk("ctrl", 64'h1, rd);
		ahb(1'b0, 32'hfc, 32'h0);
		chk("unmapped", 64'h0, rd);
		ahb(1'b1, 32'h104, 32'h7);
		ahb(1'b1, 32'h108, 32'h1017);
		ahb(1'b1, 32'h10c, 32'h3);
		ahb(1'b1, 32'h110, 32'h6);
		ahb(1'b0, 32'h108, 32'h0);
		chk("ctx readback", 64'h1017, rd);
		upd(16'ha5c1, 20'h5, 1'b1, 1'b1, 1'b0);
		chk("entry act", 64'h8, u_mem.mem[5]);
		chk("inv gran", 64'h3, gran_seen);
		chk("inv pasid", 64'h5, pasid_seen);
		// Slow memory here, since a stall exposes a skipped lock hold.
		stall <= 2'h2;
		upd(16'ha5c1, 20'h5, 1'b1, 1'b0, 1'b0);
		chk("entry act2", 64'ha, u_mem.mem[5]);
		u_mem.mem[5] = 32'hb;
		upd(16'ha5c1, 20'h5, 1'b0, 1'b0, 1'b0);
		chk("entry inact", 64'h9, u_mem.mem[5]);
		chk("inv count", 64'h1, invs);
		stall <= 2'h0;
		upd(16'h0002, 20'h28, 1'b1, 1'b1, 1'b0);
		chk("entry ptr", 64'h2, u_mem.mem[9'h128]);
		chk("entry base", 64'h9, u_mem.mem[5]);
		rd = mems;
		upd(16'h0003, 20'h5, 1'b1, 1'b0, 1'b1);
		upd(16'h0004, 20'h5, 1'b1, 1'b0, 1'b1);
		upd(16'h0001, 20'h20, 1'b1, 1'b0, 1'b1);
		upd(16'h0010, 20'h5, 1'b1, 1'b0, 1'b1);
		chk("no table access", rd, mems);
		fail <= 2'h1;
		upd(16'h0001, 20'h5, 1'b1, 1'b0, 1'b1);
		// Pending flag is set here, yet a failed write must not resync.
		fail <= 2'h2;
		upd(16'h0001, 20'h5, 1'b1, 1'b0, 1'b1);
		fail <= 2'h0;
		chk("entry kept", 64'h9, u_mem.mem[5]);
		chk("inv count2", 64'h2, invs);
		chk("unlocked access", 64'h0, lock_bad);
		chk("flushes", 64'h2, flushes);
		chk("kills", 64'h6, kills);
		ahb(1'b1, 32'h4, 32'h0);
		ahb(1'b0, 32'h4, 32'h0);
		chk("ctrl off", 64'h0, rd);
		chk("req_ready off", 64'h0, req_ready);
		ahb(1'b1, 32'h4, 32'h1);
		ahb(1'b0, 32'h8, 32'h0);
		chk("stat", 64'h000a_0002, rd);
		chk("hresp", 64'h0, hresp);
		finish_test();
	end
endmodule // pasid_state_update_handler_tb_top
`default_nettype wire

// ===== verif/psuh_mem_model.sv
// Memory and IOTLB model on the far side of the state-update handler.
// Assumes one word per state entry and answers each transfer with a pulse.
`default_nettype none
module psuh_mem_model (
	input wire logic clk,
	input wire logic mem_req,
	input wire logic mem_wr,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic inv_req,
	input wire logic [1:0] stall,
	input wire logic [1:0] fail,
	output logic mem_ack,
	output logic mem_err,
	output logic [31:0] mem_rdata,
	output logic inv_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [0:511];
	logic [1:0] wait_q = 2'h0;
	logic [31:0] rd_q = 32'h0;
	wire [8:0] idx = {mem_addr[12], mem_addr[9:2]};
	// Outside an ack the bus shows the inverse, so a stale sample shows up.
	assign mem_rdata = mem_ack ? rd_q : ~rd_q;
	initial begin
		mem_ack = 1'b0;
		mem_err = 1'b0;
		inv_done = 1'b0;
	end
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_err <= 1'b0;
		inv_done <= inv_req && !inv_done;
		wait_q <= 2'h0;
		if (mem_req && !mem_ack) begin
			if (wait_q < stall) begin
				wait_q <= wait_q + 2'h1;
			end else begin
				mem_ack <= 1'b1;
				// Bit 0 fails reads, bit 1 fails writes.
				mem_err <= mem_wr ? fail[1] : fail[0];
				rd_q <= mem[idx];
				if (mem_wr && !fail[1]) begin
					mem[idx] <= mem_wdata;
				end
			end
		end
	end
endmodule // psuh_mem_model
`default_nettype wire
